// *** dv/ompc_host.sv ***
`timescale 1ns/1ps
// ----
// Reset source and debug host
// ----
module ompc_host (
  input wire clk,
  input wire pull_en,
  input wire hold_low,
  input wire boot_low,
  input wire bkg_go,
  input wire frc_go,
  input wire [3:0] hold,
  output reg pin = 1'b1,
  output reg ms = 1'b1,
  output reg bkg = 1'b0,
  output reg frc = 1'b0
);
  reg tog = 1'b0;
  reg [3:0] bcnt = 4'h0;
  // Pin levels, floating pin toggles
  always @(posedge clk) begin
    tog <= ~tog;
    pin <= hold_low ? 1'b0 : (pull_en | tog);
    ms <= ~boot_low;
  end
  // Command held prompt or slow
  always @(posedge clk) begin
    if (bkg_go)
      bcnt <= hold;
    else if (bcnt != 4'h0)
      bcnt <= bcnt - 4'h1;
    bkg <= bkg_go | (bcnt > 4'h1);
    frc <= frc_go;
  end
endmodule

// *** dv/ompc_props.sv ***
`timescale 1ns/1ps
// ----
// Mode checker
// ----
module ompc_props (
  input wire CLK,
  input wire NRST,
  input wire POR_N,
  input wire SHARED_PIN_IN,
  input wire DEBUG_UNIT_BREAK,
  input wire PIN_RESET_N,
  input wire PORT_A5_IN,
  input wire PIN_PULLUP_EN,
  input wire CPU_RUN,
  input wire CPU_CLK_EN,
  input wire BUS_CLK_EN,
  input wire REG_FULL_EN,
  input wire CORE_PWR_EN,
  input wire RAM_PWR_EN,
  input wire VEC_FETCH,
  input wire [15:0] VEC_ADDR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_fn; PIN_PULLUP_EN |-> !PORT_A5_IN; endproperty
  a_fn: assert property (p_fn) else $error("port fn with select");
  property p_keep; PIN_PULLUP_EN && POR_N |=> PIN_PULLUP_EN; endproperty
  a_keep: assert property (p_keep) else $error("select lost");
  property p_prst; (PIN_PULLUP_EN && !SHARED_PIN_IN)[*4] |-> !PIN_RESET_N; endproperty
  a_prst: assert property (p_prst) else $error("pin reset missed");
  property p_stop; !BUS_CLK_EN |-> !CPU_CLK_EN && !CPU_RUN; endproperty
  a_stop: assert property (p_stop) else $error("cpu clock in stop");
  property p_full; BUS_CLK_EN |-> REG_FULL_EN && CORE_PWR_EN && RAM_PWR_EN; endproperty
  a_full: assert property (p_full) else $error("power cut with clocks");
  property p_ram; !RAM_PWR_EN |-> !CORE_PWR_EN && !BUS_CLK_EN; endproperty
  a_ram: assert property (p_ram) else $error("ram off alone");
  property p_vec; $rose(VEC_FETCH) |->
    (VEC_FETCH && VEC_ADDR == 16'hfffe)[*6] ##1 !VEC_FETCH; endproperty
  a_vec: assert property (p_vec) else $error("fetch length");
  property p_vrun; VEC_FETCH |-> !CPU_RUN; endproperty
  a_vrun: assert property (p_vrun) else $error("run during fetch");
  property p_brk; $rose(DEBUG_UNIT_BREAK) |-> ##[1:5] !CPU_RUN; endproperty
  a_brk: assert property (p_brk) else $error("break ignored");
endmodule

// *** dv/tb_operating_mode_power_control.sv ***
`timescale 1ns/1ps
`include "ompc_defs.vh"
// ----
// Bench top
// ----
module tb_operating_mode_power_control;
  reg CLK, NRST, POR_N, HSEL, HWRITE, WAKEUP, BKGD_INSTR, DEBUG_CTRL_BREAK, DEBUG_UNIT_BREAK;
  reg [31:0] HADDR, HWDATA, rnd;
  reg [1:0] HTRANS;
  reg [2:0] HSIZE;
  reg [3:0] hold;
  reg hold_low, boot_low, bkg_go, frc_go, rd_ph;
  wire [31:0] HRDATA;
  wire [15:0] VEC_ADDR;
  wire HREADYOUT, HRESP, PIN_RESET_N, PORT_A5_IN, PIN_PULLUP_EN, CPU_RUN, CPU_CLK_EN;
  wire BUS_CLK_EN, REG_FULL_EN, CORE_PWR_EN, RAM_PWR_EN, VEC_FETCH;
  wire SHARED_PIN_IN, MODE_SELECT_IN, DEBUG_BKG_CMD, DEBUG_FORCE_RESET;
  int err_total, cmp_count, cyc, i;
  logic [63:0] expq[$];
  logic [63:0] e;
  localparam int SETTLE = 14;
  ompc_top u_dut (.CLK(CLK), .NRST(NRST), .POR_N(POR_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SHARED_PIN_IN(SHARED_PIN_IN),
    .MODE_SELECT_IN(MODE_SELECT_IN), .DEBUG_BKG_CMD(DEBUG_BKG_CMD),
    .DEBUG_FORCE_RESET(DEBUG_FORCE_RESET), .BKGD_INSTR(BKGD_INSTR),
    .DEBUG_CTRL_BREAK(DEBUG_CTRL_BREAK), .DEBUG_UNIT_BREAK(DEBUG_UNIT_BREAK), .WAKEUP(WAKEUP),
    .PIN_RESET_N(PIN_RESET_N), .PORT_A5_IN(PORT_A5_IN), .PIN_PULLUP_EN(PIN_PULLUP_EN),
    .CPU_RUN(CPU_RUN), .CPU_CLK_EN(CPU_CLK_EN), .BUS_CLK_EN(BUS_CLK_EN),
    .REG_FULL_EN(REG_FULL_EN), .CORE_PWR_EN(CORE_PWR_EN), .RAM_PWR_EN(RAM_PWR_EN),
    .VEC_FETCH(VEC_FETCH), .VEC_ADDR(VEC_ADDR));
  ompc_host u_host (.clk(CLK), .pull_en(PIN_PULLUP_EN), .hold_low(hold_low),
    .boot_low(boot_low), .bkg_go(bkg_go), .frc_go(frc_go), .hold(hold),
    .pin(SHARED_PIN_IN), .ms(MODE_SELECT_IN), .bkg(DEBUG_BKG_CMD), .frc(DEBUG_FORCE_RESET));
  // Clock
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // Cycle ceiling
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      conclude();
    end
  end
  // Read data against oldest note
  always @(posedge CLK) begin
    if (rd_ph === 1'b1 && HREADYOUT === 1'b1) begin
      e = expq.pop_front();
      chk("HRDATA", e[31:0], HRDATA & e[63:32]);
      chk("HRESP", 32'h0, {31'h0, HRESP});
    end
  end
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [31:0] pv();
    pv = {23'h0, CPU_CLK_EN, PIN_PULLUP_EN, PORT_A5_IN, PIN_RESET_N, CPU_RUN, BUS_CLK_EN,
      CORE_PWR_EN, RAM_PWR_EN, REG_FULL_EN};
  endfunction
  task chk(input string n, input [31:0] x, input [31:0] g);
    begin
      cmp_count++;
      if (g !== x) begin
        err_total++;
        $display("ERROR %s exp %h got %h", n, x, g);
      end
    end
  endtask
  task pins(input [31:0] x, input [31:0] m);
    begin
      @(negedge CLK);
      chk("PINS", x, pv() & m);
      @(posedge CLK);
    end
  endtask
  task conclude;
    begin
      if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // Single word transfer, read notes expected data
  task xf(input w, input [7:0] a, input [31:0] d, input [31:0] m);
    begin
      HSEL <= 1'b1;
      HTRANS <= `OMPC_HTRANS_NONSEQ;
      HADDR <= {24'h0, a};
      HWRITE <= w;
      tick(1);
      while (HREADYOUT !== 1'b1) tick(1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= w ? d : 32'h0;
      rd_ph <= !w;
      if (!w) expq.push_back({m, d});
      tick(1);
      while (HREADYOUT !== 1'b1) tick(1);
      rd_ph <= 1'b0;
    end
  endtask
  task rst(input p);
    begin
      NRST <= 1'b0;
      POR_N <= !p;
      tick(5);
      NRST <= 1'b1;
      POR_N <= 1'b1;
      tick(SETTLE);
    end
  endtask
  task wake;
    begin
      WAKEUP <= 1'b1;
      tick(1);
      WAKEUP <= 1'b0;
    end
  endtask
  // Main sequence
  initial begin
    {NRST, POR_N, HSEL, HWRITE, WAKEUP, BKGD_INSTR, DEBUG_CTRL_BREAK, DEBUG_UNIT_BREAK} = 8'h0;
    {hold_low, boot_low, bkg_go, frc_go, rd_ph} = 5'h0;
    HADDR = 32'h0;
    HWDATA = 32'h0;
    HTRANS = 2'h0;
    HSIZE = `OMPC_HSIZE_WORD;
    hold = 4'h1;
    rnd = 32'h7;
    tick(1);
    rst(1'b1);
    xf(0, `OMPC_ADDR_PMC, 32'h0, 32'h1f);
    xf(0, `OMPC_ADDR_MODE, 32'h1, 32'h7);
    pins(32'h13f, 32'h1bf);
    rnd = xs(rnd);
    xf(1, 8'h40, rnd, 32'h0);
    xf(0, 8'h40, 32'h0, 32'hffffffff);
    xf(1, `OMPC_ADDR_PMC, 32'h0, 32'h0);
    xf(1, `OMPC_ADDR_PMC, 32'h3, 32'h0);
    xf(0, `OMPC_ADDR_PMC, 32'h0, 32'h3);
    xf(1, `OMPC_ADDR_CMD, 32'h1, 32'h0);
    tick(2);
    pins(32'h26, 32'h13e);
    xf(0, `OMPC_ADDR_MODE, 32'h4, 32'h7);
    wake();
    tick(4);
    xf(0, `OMPC_ADDR_MODE, 32'h1, 32'h7);
    for (i = 0; i < 2; i++) begin
      rst(1'b0);
      xf(1, `OMPC_ADDR_PMC, i ? 32'h3 : 32'h2, 32'h0);
      xf(1, `OMPC_ADDR_CMD, 32'h1, 32'h0);
      tick(2);
      pins(i ? 32'h22 : 32'h20, 32'h13e);
      wake();
      tick(SETTLE);
      xf(0, `OMPC_ADDR_PMC, i ? 32'h8 : 32'h10, 32'h1f);
      xf(1, `OMPC_ADDR_PMC, 32'h4, 32'h0);
      xf(0, `OMPC_ADDR_PMC, 32'h0, 32'h18);
    end
    xf(1, `OMPC_ADDR_CMD, 32'h2, 32'h0);
    tick(2);
    pins(32'h2f, 32'h13f);
    xf(1, `OMPC_ADDR_CMD, 32'h4, 32'h0);
    xf(0, `OMPC_ADDR_MODE, 32'h1, 32'h7);
    for (i = 0; i < 5; i++) begin
      rnd = xs(rnd);
      hold <= {1'b0, rnd[2:0]} + 4'h1;
      case (i)
        0: bkg_go <= 1'b1;
        1: BKGD_INSTR <= 1'b1;
        2: DEBUG_CTRL_BREAK <= 1'b1;
        3: DEBUG_UNIT_BREAK <= 1'b1;
        default: frc_go <= 1'b1;
      endcase
      tick(1);
      {bkg_go, BKGD_INSTR, DEBUG_CTRL_BREAK, DEBUG_UNIT_BREAK, frc_go} <= 5'h0;
      tick(SETTLE);
      xf(0, `OMPC_ADDR_MODE, 32'h2, 32'h7);
      xf(1, `OMPC_ADDR_CMD, 32'h8, 32'h0);
      xf(0, `OMPC_ADDR_MODE, 32'h1, 32'h7);
    end
    boot_low <= 1'b1;
    rst(1'b1);
    xf(0, `OMPC_ADDR_MODE, 32'h2, 32'h7);
    boot_low <= 1'b0;
    xf(1, `OMPC_ADDR_SOPT, 32'h1, 32'h0);
    xf(1, `OMPC_ADDR_SOPT, 32'h0, 32'h0);
    tick(2);
    pins(32'h80, 32'hc0);
    NRST <= 1'b0;
    tick(2);
    pins(32'h80, 32'hc0);
    rst(1'b0);
    pins(32'h80, 32'hc0);
    hold_low <= 1'b1;
    tick(6);
    pins(32'h80, 32'ha0);
    hold_low <= 1'b0;
    rst(1'b1);
    pins(32'h0, 32'h80);
    hold_low <= 1'b1;
    tick(6);
    pins(32'h20, 32'he0);
    conclude();
  end
endmodule

bind ompc_top ompc_props u_props (.CLK(CLK), .NRST(NRST), .POR_N(POR_N),
  .SHARED_PIN_IN(SHARED_PIN_IN), .DEBUG_UNIT_BREAK(DEBUG_UNIT_BREAK),
  .PIN_RESET_N(PIN_RESET_N), .PORT_A5_IN(PORT_A5_IN), .PIN_PULLUP_EN(PIN_PULLUP_EN),
  .CPU_RUN(CPU_RUN), .CPU_CLK_EN(CPU_CLK_EN), .BUS_CLK_EN(BUS_CLK_EN),
  .REG_FULL_EN(REG_FULL_EN), .CORE_PWR_EN(CORE_PWR_EN), .RAM_PWR_EN(RAM_PWR_EN),
  .VEC_FETCH(VEC_FETCH), .VEC_ADDR(VEC_ADDR));

// *** rtl/ompc_defs.vh ***
`ifndef OMPC_DEFS_VH
`define OMPC_DEFS_VH

// ----------------------------------------------------------------
// Register map (byte addresses, one word each)
// ----------------------------------------------------------------
`define OMPC_ADDR_PMC 8'h00
`define OMPC_ADDR_SOPT 8'h04
`define OMPC_ADDR_MODE 8'h08
`define OMPC_ADDR_CMD 8'h0c
`define OMPC_ADDR_W 8

// ----------------------------------------------------------------
// Power-down mode control bits
// ----------------------------------------------------------------
`define OMPC_PMC_SEL 0
`define OMPC_PMC_EN 1
`define OMPC_PMC_ACK 2
`define OMPC_PMC_PPF 3
`define OMPC_PMC_FPF 4

// System options one: reset pin select bit
`define OMPC_SOPT_RPS 0

// Command register bits
`define OMPC_CMD_STOP 0
`define OMPC_CMD_WAIT 1
`define OMPC_CMD_WAKE 2
`define OMPC_CMD_GO 3

// ----------------------------------------------------------------
// Mode status field codes
// ----------------------------------------------------------------
`define OMPC_MD_VEC 3'h0
`define OMPC_MD_RUN 3'h1
`define OMPC_MD_BKG 3'h2
`define OMPC_MD_WAIT 3'h3
`define OMPC_MD_STOP 3'h4

// Stop depth codes
`define OMPC_STOP_NONE 2'h0
`define OMPC_STOP_FULL 2'h1
`define OMPC_STOP_PART 2'h2
`define OMPC_STOP_RET 2'h3

// Vector fetch sequence length in cycles
`define OMPC_VEC_CYCLES 3'h6
`define OMPC_VEC_ADDR 16'hfffe

// AHB encodings
`define OMPC_HTRANS_NONSEQ 2'h2
`define OMPC_HSIZE_WORD 3'h2

`endif

// *** rtl/ompc_top.v ***
// Behaviour
// R1: After power-on the shared pin is a port input until reset select is set.
// R2: Once select is set it stays until next power-on reset.
// R3: With select set, the shared pin driven low resets the device.
// R4: Pullup of the shared pin is on whenever select is 1.
// R5: Mode-select high at reset exit enters run, vector at 0xFFFE:0xFFFF.
// R6: Mode-select low at power-on or after debug-forced reset enters background.
// R7: Background command on the debug pin enters background mode.
// R8: Background-entry instruction enters background mode.
// R9: Breakpoint from debug controller or debug unit enters background mode.
// R10: Wait halts the CPU, clocks keep running, full regulation kept. The code also gates the CPU clock (CPU_CLK_EN low) in wait; the bus clock runs.
// R11: Every stop mode stops both CPU and bus clocks.
// R12: Full power-down stop powers everything down, nothing retained.
// R13: Partial power-down stop keeps RAM powered, the rest off.
// R14: Retained stop keeps all circuits powered.
// R15: Bit 4 reads 1 after recovery from full power-down stop.
// R16: Bit 3 reads 1 after recovery from partial power-down stop.
// R17: Writing 1 to bit 2 clears both recovery flags.
// R18: Bit 1 enables power-down stop modes.
// R19: Bit 0 selects full (0) or partial (1) power-down.
// R20: Write-once bits take only the first write after reset.
// R21: Six-cycle vector fetch precedes the first instruction after reset.
// R22: Stop request with power-down disabled enters retained stop.
// R23: Power-on reset clears recovery flags and write-once control bits.
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "ompc_defs.vh"

module ompc_top (
  input wire CLK,
  input wire NRST,
  input wire POR_N,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire SHARED_PIN_IN,
  input wire MODE_SELECT_IN,
  input wire DEBUG_BKG_CMD,
  input wire DEBUG_FORCE_RESET,
  input wire BKGD_INSTR,
  input wire DEBUG_CTRL_BREAK,
  input wire DEBUG_UNIT_BREAK,
  input wire WAKEUP,
  output reg PIN_RESET_N,
  output reg PORT_A5_IN,
  output reg PIN_PULLUP_EN,
  output reg CPU_RUN,
  output reg CPU_CLK_EN,
  output reg BUS_CLK_EN,
  output reg REG_FULL_EN,
  output reg CORE_PWR_EN,
  output reg RAM_PWR_EN,
  output reg VEC_FETCH,
  output reg [15:0] VEC_ADDR
);

  // ----------------------------------------------------------------
  // Local state codes, one-hot
  // ----------------------------------------------------------------
  localparam ST_VEC = 5'h01;
  localparam ST_RUN = 5'h02;
  localparam ST_BKG = 5'h04;
  localparam ST_WAIT = 5'h08;
  localparam ST_STOP = 5'h10;

  // Full 8-bit byte-address decode used by read and write paths
  function is_addr;
    input [`OMPC_ADDR_W-1:0] a;
    input [`OMPC_ADDR_W-1:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [6:0] sync1_reg;
  reg [6:0] sync2_reg;
  wire [6:0] pins_raw = {WAKEUP, DEBUG_UNIT_BREAK, DEBUG_CTRL_BREAK, DEBUG_FORCE_RESET,
                         DEBUG_BKG_CMD, MODE_SELECT_IN, SHARED_PIN_IN};

  // Two flops on the shared pin, mode-select, debug and wakeup inputs; BKGD_INSTR and the bus are not synchronised
  always @(posedge CLK) begin
    sync1_reg <= pins_raw;
    sync2_reg <= sync1_reg;
  end

  wire pin_s = sync2_reg[0];
  wire ms_s = sync2_reg[1];
  wire bkg_cmd_s = sync2_reg[2];
  wire force_rst_s = sync2_reg[3];
  wire brk_s = sync2_reg[4] | sync2_reg[5];
  wire wake_s = sync2_reg[6];

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  reg wr_pend_reg;
  reg [`OMPC_ADDR_W-1:0] addr_reg;
  wire ap_valid = HSEL & HREADY & (HTRANS == `OMPC_HTRANS_NONSEQ);
  wire wr_pmc = wr_pend_reg & is_addr(addr_reg, `OMPC_ADDR_PMC);
  wire wr_sopt = wr_pend_reg & is_addr(addr_reg, `OMPC_ADDR_SOPT);
  wire wr_cmd = wr_pend_reg & is_addr(addr_reg, `OMPC_ADDR_CMD);

  // Address phase capture, zero wait states
  always @(posedge CLK) begin
    if (!NRST) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= {`OMPC_ADDR_W{1'b0}};
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      wr_pend_reg <= ap_valid & HWRITE;
      if (ap_valid) begin
        addr_reg <= HADDR[`OMPC_ADDR_W-1:0];
      end
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power-on and reset domain registers
  // ----------------------------------------------------------------
  reg rps_reg;
  reg pd_en_reg;
  reg pd_sel_reg;
  reg pmc_wrote_reg;
  reg full_flag_reg;
  reg part_flag_reg;
  reg [1:0] stop_kind_reg;
  reg wake_pending_reg;

  // Recovery from a power-down stop ends in a reset; record which
  wire recover_full = wake_pending_reg & (stop_kind_reg == `OMPC_STOP_FULL);
  wire recover_part = wake_pending_reg & (stop_kind_reg == `OMPC_STOP_PART);
  wire ack_wr = wr_pmc & HWDATA[`OMPC_PMC_ACK];

  // Survive pin resets, cleared by power-on reset; the recovery flags also by the ack write
  always @(posedge CLK) begin
    if (!POR_N) begin
      // R23 power-on clears
      rps_reg <= 1'b0;
      full_flag_reg <= 1'b0;
      part_flag_reg <= 1'b0;
    end else begin
      // R1 R2 sticky select
      if (wr_sopt & HWDATA[`OMPC_SOPT_RPS]) begin
        rps_reg <= 1'b1;
      end
      // R15 R16 R17 set wins over ack
      if (recover_full) begin
        full_flag_reg <= 1'b1;
      end else if (ack_wr) begin
        full_flag_reg <= 1'b0;
      end
      if (recover_part) begin
        part_flag_reg <= 1'b1;
      end else if (ack_wr) begin
        part_flag_reg <= 1'b0;
      end
    end
  end

  // Write-once controls, cleared by pin or power-on reset or power-down recovery, not by debug-forced reset
  always @(posedge CLK) begin
    // R12 R13 controls not retained
    if (!NRST || !POR_N || wake_pending_reg) begin
      pd_en_reg <= 1'b0;
      pd_sel_reg <= 1'b0;
      pmc_wrote_reg <= 1'b0;
    end else if (wr_pmc && !pmc_wrote_reg) begin
      // R20 first write only; R18 R19 controls
      pd_en_reg <= HWDATA[`OMPC_PMC_EN];
      pd_sel_reg <= HWDATA[`OMPC_PMC_SEL];
      pmc_wrote_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [2:0] vec_cnt_reg;
  reg boot_bkg_reg;
  reg first_reg;
  wire stop_req = wr_cmd & HWDATA[`OMPC_CMD_STOP];
  wire wait_req = wr_cmd & HWDATA[`OMPC_CMD_WAIT];
  wire wake_cmd = wr_cmd & HWDATA[`OMPC_CMD_WAKE];
  wire go_cmd = wr_cmd & HWDATA[`OMPC_CMD_GO];
  wire bkg_entry = bkg_cmd_s | BKGD_INSTR | brk_s;

  // Next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_VEC: begin
        // R21 six-cycle vector fetch
        if (vec_cnt_reg == `OMPC_VEC_CYCLES - 3'h1) begin
          // R5 R6 run or background
          state_next = boot_bkg_reg ? ST_BKG : ST_RUN;
        end
      end
      ST_RUN: begin
        // R7 R8 R9 background entry
        if (bkg_entry) begin
          state_next = ST_BKG;
        end else if (stop_req) begin
          state_next = ST_STOP;
        end else if (wait_req) begin
          state_next = ST_WAIT;
        end
      end
      ST_BKG: begin
        if (go_cmd) begin
          state_next = ST_RUN;
        end
      end
      ST_WAIT: begin
        if (bkg_entry) begin
          state_next = ST_BKG;
        end else if (wake_s | wake_cmd) begin
          state_next = ST_RUN;
        end
      end
      ST_STOP: begin
        if (wake_s) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_VEC;
    endcase
  end

  // Debug-forced reset and power-on both latch the boot mode
  always @(posedge CLK) begin
    if (!NRST || !POR_N) begin
      state_reg <= ST_VEC;
      vec_cnt_reg <= 3'h0;
      first_reg <= 1'b1;
      boot_bkg_reg <= 1'b0;
      stop_kind_reg <= `OMPC_STOP_NONE;
      wake_pending_reg <= 1'b0;
    end else if (force_rst_s) begin
      // R6 background after forced reset
      state_reg <= ST_VEC;
      vec_cnt_reg <= 3'h0;
      boot_bkg_reg <= 1'b1;
      stop_kind_reg <= `OMPC_STOP_NONE;
      wake_pending_reg <= 1'b0;
    end else begin
      first_reg <= 1'b0;
      if (first_reg) begin
        // R6 mode-select sampled at reset release
        boot_bkg_reg <= ~ms_s;
      end
      if (state_reg == ST_VEC) begin
        vec_cnt_reg <= vec_cnt_reg + 3'h1;
      end else begin
        vec_cnt_reg <= 3'h0;
      end
      wake_pending_reg <= 1'b0;
      if (state_reg == ST_STOP && wake_s) begin
        // Power-down stops recover through a reset sequence
        if (stop_kind_reg != `OMPC_STOP_RET) begin
          wake_pending_reg <= 1'b1;
          state_reg <= ST_VEC;
          boot_bkg_reg <= ~ms_s;
        end else begin
          state_reg <= state_next;
          stop_kind_reg <= `OMPC_STOP_NONE;
        end
      end else begin
        state_reg <= state_next;
      end
      if (state_reg == ST_RUN && state_next == ST_STOP) begin
        // R22 retained when disabled; R19 select
        stop_kind_reg <= !pd_en_reg ? `OMPC_STOP_RET :
                         (pd_sel_reg ? `OMPC_STOP_PART : `OMPC_STOP_FULL);
      end
      if (wake_pending_reg) begin
        stop_kind_reg <= `OMPC_STOP_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  wire in_stop = (state_reg == ST_STOP);

  // Pin, clock and power controls
  always @(posedge CLK) begin
    if (!NRST) begin
      PIN_RESET_N <= 1'b1;
      PORT_A5_IN <= 1'b0;
      CPU_RUN <= 1'b0;
      CPU_CLK_EN <= 1'b1;
      BUS_CLK_EN <= 1'b1;
      REG_FULL_EN <= 1'b1;
      CORE_PWR_EN <= 1'b1;
      RAM_PWR_EN <= 1'b1;
      VEC_FETCH <= 1'b0;
      VEC_ADDR <= `OMPC_VEC_ADDR;
    end else begin
      // R3 pin low requests reset only when selected
      PIN_RESET_N <= ~(rps_reg & ~pin_s);
      PORT_A5_IN <= rps_reg ? 1'b0 : pin_s;
      // R10 CPU halted in wait and background
      CPU_RUN <= (state_reg == ST_RUN);
      // R11 clocks stopped in stop
      CPU_CLK_EN <= ~in_stop & (state_reg != ST_WAIT);
      BUS_CLK_EN <= ~in_stop;
      REG_FULL_EN <= ~in_stop;
      // R12 R13 R14 power domains
      CORE_PWR_EN <= ~(in_stop & (stop_kind_reg == `OMPC_STOP_FULL
                                  || stop_kind_reg == `OMPC_STOP_PART));
      RAM_PWR_EN <= ~(in_stop & (stop_kind_reg == `OMPC_STOP_FULL));
      VEC_FETCH <= (state_reg == ST_VEC);
      // R5 reset vector address
      VEC_ADDR <= `OMPC_VEC_ADDR;
    end
  end

  // Pullup follows the select through pin resets, so a selected
  // reset pin is never left floating while it is held low
  always @(posedge CLK) begin
    if (!POR_N) begin
      PIN_PULLUP_EN <= 1'b0;
    end else begin
      // R4 automatic pullup
      PIN_PULLUP_EN <= rps_reg;
    end
  end

  // Mode code for status read
  reg [2:0] mode_code;
  always @* begin
    case (state_reg)
      ST_RUN: mode_code = `OMPC_MD_RUN;
      ST_BKG: mode_code = `OMPC_MD_BKG;
      ST_WAIT: mode_code = `OMPC_MD_WAIT;
      ST_STOP: mode_code = `OMPC_MD_STOP;
      default: mode_code = `OMPC_MD_VEC;
    endcase
  end

  // Read data, registered at address phase
  always @(posedge CLK) begin
    if (!NRST) begin
      HRDATA <= 32'h0;
    end else if (ap_valid & ~HWRITE) begin
      HRDATA <= 32'h0;
      if (is_addr(HADDR[`OMPC_ADDR_W-1:0], `OMPC_ADDR_PMC)) begin
        HRDATA[`OMPC_PMC_FPF] <= full_flag_reg;
        HRDATA[`OMPC_PMC_PPF] <= part_flag_reg;
        HRDATA[`OMPC_PMC_EN] <= pd_en_reg;
        HRDATA[`OMPC_PMC_SEL] <= pd_sel_reg;
      end else if (is_addr(HADDR[`OMPC_ADDR_W-1:0], `OMPC_ADDR_SOPT)) begin
        HRDATA[`OMPC_SOPT_RPS] <= rps_reg;
      end else if (is_addr(HADDR[`OMPC_ADDR_W-1:0], `OMPC_ADDR_MODE)) begin
        HRDATA[2:0] <= mode_code;
      end
    end
  end

endmodule
